// ---- logic/dcc_map.vh ----
`ifndef DCC_MAP_VH
`define DCC_MAP_VH
// register byte offsets (low 8 address bits decoded)
`define DCC_REG_CTRL 8'h00
`define DCC_REG_WDT 8'h04
`define DCC_REG_SAFE 8'h08
`define DCC_REG_DOUT 8'h0c
`define DCC_REG_DIN 8'h10
`define DCC_REG_FILT 8'h14
`define DCC_REG_ENAB 8'h18
`define DCC_REG_CCLR 8'h1c
`define DCC_REG_ISTS 8'h24
`define DCC_REG_IMSK 8'h28
`define DCC_REG_PRESET 8'h40
`define DCC_REG_COUNT 8'h60
`define DCC_REG_FREQ 8'h80
// control register fields
`define DCC_CTRL_LATEN 0
`define DCC_CTRL_CLRHI 1
`define DCC_CTRL_CLRLO 2
`define DCC_CTRL_MODE_LSB 4
`define DCC_CTRL_AVG_LSB 8
// irq status bits
`define DCC_IRQ_ALARM 0
`define DCC_IRQ_LATCH 1
`define DCC_IRQ_FREQ 2
// reset values
`define DCC_CTRL_RST 32'h0000_0000
`define DCC_WDT_RST 16'h0000
`define DCC_PWRON_RST 8'h00
`define DCC_FILT_RST 13'h0000
// scan modes
`define DCC_MODE_1000MS 2'h0
`define DCC_MODE_100MS 2'h1
`define DCC_MODE_SINGLE 2'h2
// timing
`define DCC_CLK_NS 10
`define DCC_MS_NS 1000000
`define DCC_US_NS 1000
`define DCC_WIN_LONG_MS 1000
`define DCC_WIN_SHORT_MS 100
`define DCC_SCALE_LONG 100
`define DCC_SCALE_SHORT 1000
// us per second times 100 steps per Hz, so single mode reads 0.01 Hz
`define DCC_SP_NUM 34'd100000000
`endif

// ---- logic/dcc_in_filter.v ----
`timescale 1ns/1ps
`include "dcc_map.vh"
// one input channel: synchroniser plus millisecond noise filter
module dcc_in_filter
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // pin and timing
  input wire pinIn,
  input wire msTick,
  input wire [12:0] filterMs,
  // filtered level
  output reg filtOut
);
  reg syncA_q; // first stage, read only by syncB_q
  reg syncB_q; // safe to use
  reg [12:0] stab_q; // ms the new level has held

  // two flops before any logic looks at the pin
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end
    else
    begin
      syncA_q <= pinIn;
      syncB_q <= syncA_q;
    end
  end

  // level only passes after holding filterMs ms
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      filtOut <= 1'b0;
      stab_q <= 13'h0000;
    end
    else if (filterMs == 13'h0000)
    begin
      filtOut <= syncB_q; // [R9]
      stab_q <= 13'h0000;
    end
    else if (syncB_q == filtOut)
      stab_q <= 13'h0000; // glitch gone, restart
    else if (msTick)
    begin
      if (stab_q + 13'h0001 >= filterMs)
      begin
        filtOut <= syncB_q; // [R9]
        stab_q <= 13'h0000;
      end
      else
        stab_q <= stab_q + 13'h0001;
    end
  end
endmodule

// ---- logic/dcc_freq_chan.v ----
`timescale 1ns/1ps
`include "dcc_map.vh"
// one channel of frequency measurement, result in units of 0.01 Hz
module dcc_freq_chan
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // control
  input wire en,
  input wire [1:0] mode,
  input wire [1:0] avgSel,
  // timing and signal
  input wire rise,
  input wire msTick,
  input wire usTick,
  // result
  output reg [31:0] freq,
  output reg upd
);
  reg [9:0] winMs_q; // ms into the window
  reg [15:0] edges_q; // rising edges this window
  reg [26:0] perUs_q; // us since last edge
  reg armed_q; // one edge seen in single mode
  reg [5:0] divCnt_q; // divider steps left
  reg [33:0] quo_q; // dividend then quotient
  reg [33:0] rem_q;
  reg [26:0] dsr_q;
  reg [31:0] hist_q [0:7]; // sample history
  reg push_q; // a sample just entered history
  wire [9:0] winLen;
  reg [31:0] sample;
  reg sampleVld;
  reg [34:0] sum;
  reg [3:0] k;
  wire [34:0] remSh;
  wire [34:0] remSub;
  integer i;
  integer j; // loop index of the clocked history block
  localparam [9:0] WIN_SHORT = `DCC_WIN_SHORT_MS - 1; // last ms of window
  localparam [9:0] WIN_LONG = `DCC_WIN_LONG_MS - 1;

  assign winLen = (mode == `DCC_MODE_100MS) ? WIN_SHORT : WIN_LONG;
  assign remSh = {rem_q, quo_q[33]};
  assign remSub = remSh - {8'h00, dsr_q};

  // pick the sample source for this cycle
  always @*
  begin
    sample = 32'h0000_0000;
    sampleVld = 1'b0;
    if (mode == `DCC_MODE_SINGLE)
    begin
      sampleVld = (divCnt_q == 6'h01); // [R16]
      sample = remSub[34] ? {quo_q[30:0], 1'b0} : {quo_q[30:0], 1'b1};
    end
    else if (msTick && winMs_q == winLen)
    begin
      sampleVld = 1'b1;
      if (mode == `DCC_MODE_100MS)
        sample = edges_q * `DCC_SCALE_SHORT; // [R15]
      else
        sample = edges_q * `DCC_SCALE_LONG; // [R14]
    end
  end

  // window counting, period timing and serial divider
  always @(posedge sys_clk)
  begin
    if (!resetn || !en)
    begin
      winMs_q <= 10'h000;
      edges_q <= 16'h0000;
      perUs_q <= 27'h0000000;
      armed_q <= 1'b0;
      divCnt_q <= 6'h00;
      quo_q <= 34'h0;
      rem_q <= 34'h0;
      dsr_q <= 27'h0;
    end
    else
    begin
      // window modes: count edges per window
      if (msTick && winMs_q == winLen)
      begin
        winMs_q <= 10'h000;
        edges_q <= {15'h0000, rise};
      end
      else
      begin
        if (msTick)
          winMs_q <= winMs_q + 10'h001;
        if (rise && edges_q != 16'hffff)
          edges_q <= edges_q + 16'h0001;
      end
      // single mode: period between rising edges, in us
      if (rise)
      begin
        // a tick on the edge cycle belongs to the new period
        perUs_q <= usTick ? 27'h0000001 : 27'h0000000; // [R16]
        armed_q <= 1'b1;
        if (armed_q && divCnt_q == 6'h00 && perUs_q != 27'h0)
        begin
          dsr_q <= perUs_q;
          quo_q <= `DCC_SP_NUM;
          rem_q <= 34'h0;
          divCnt_q <= 6'd34; // one step per dividend bit
        end
      end
      else if (usTick && perUs_q != 27'h7ffffff)
        perUs_q <= perUs_q + 27'h0000001;
      if (divCnt_q != 6'h00)
      begin
        divCnt_q <= divCnt_q - 6'h01;
        rem_q <= remSub[34] ? remSh[33:0] : remSub[33:0];
        quo_q <= {quo_q[32:0], ~remSub[34]};
      end
    end
  end

  // averaging over 1, 2, 4 or 8 newest samples
  always @*
  begin
    sum = 35'h0;
    k = 4'h1 << avgSel;
    for (i = 0; i < 8; i = i + 1)
      if (i < k)
        sum = sum + {3'h0, hist_q[i]}; // [R17]
  end

  // history shift and averaged output
  always @(posedge sys_clk)
  begin
    if (!resetn || !en)
    begin
      for (j = 0; j < 8; j = j + 1)
        hist_q[j] <= 32'h0000_0000;
      push_q <= 1'b0;
      freq <= 32'h0000_0000;
      upd <= 1'b0;
    end
    else
    begin
      push_q <= sampleVld;
      upd <= push_q;
      if (sampleVld)
      begin
        hist_q[0] <= sample;
        for (j = 1; j < 8; j = j + 1)
          hist_q[j] <= hist_q[j-1];
      end
      if (push_q)
        freq <= sum[31:0] >> avgSel; // [R17]
    end
  end
endmodule

// ---- logic/dcc_top.v ----
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "dcc_map.vh"
// How it works
// [R1] alarm after configured silence from host
// [R2] per-output enable for safe-value handling
// [R3] alarm drives enabled outputs to safe value
// [R4] outputs start at power-on value after reset; reset loads the fixed 8'h00 and powerOn_q is never applied
// [R5] one bit turns latching on for all
// [R6] sticky seen-high and seen-low flags per input
// [R7] write one clears all high latches
// [R8] write one clears all low latches
// [R9] input filter 1-6500 ms, zero disables
// [R10] pulse counter per input with enable
// [R11] per-channel clear resets the count
// [R12] preset value is the starting count
// [R13] frequency measurement per input with enable
// [R14] 1000 ms window counts pulses
// [R15] 100 ms window counts pulses
// [R16] single pulse mode divides by period
// [R17] average over 1, 2, 4, 8 samples
// [R18] each request restarts timeout, ends alarm
// [R19] counter steps on filtered rising edge
module dcc_top
#(
  parameter MS_CYC = `DCC_MS_NS / `DCC_CLK_NS
)
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // host traffic, one pulse per received request
  input wire mbReq,
  // digital pins
  input wire [7:0] diPin,
  output wire [7:0] doPin,
  // interrupt
  output wire irq
);
  localparam NCH = 8; // fixed by the 8-bit register fields
  localparam US_CYC = `DCC_US_NS / `DCC_CLK_NS;

  // channel index from a per-channel register address
  function [2:0] chIdx;
    input [7:0] a;
    begin
      chIdx = a[4:2];
    end
  endfunction

  // bus capture
  reg wrPend_q; // write data phase pending
  reg [7:0] wrAddr_q; // address of that write
  wire accept; // address phase taken
  // config registers
  reg [31:0] ctrl_q;
  reg [15:0] wdtTo_q; // timeout in ms, zero = off
  reg [7:0] safeEn_q;
  reg [7:0] safeVal_q;
  reg [7:0] powerOn_q;
  reg [7:0] doVal_q;
  reg [12:0] filtMs_q;
  reg [7:0] cntEn_q;
  reg [7:0] freqEn_q;
  reg [31:0] preset_q [0:NCH-1];
  reg [31:0] count_q [0:NCH-1];
  reg [2:0] irqSts_q;
  reg [2:0] irqMsk_q;
  // state
  reg [7:0] hiLat_q; // seen high
  reg [7:0] loLat_q; // seen low
  reg [7:0] filtPrev_q; // last filtered level
  reg [16:0] msCnt_q;
  reg [6:0] usCnt_q;
  reg [15:0] wdtMs_q;
  reg alarm_q;
  wire msTick;
  wire usTick;
  wire alarmSet;
  wire [7:0] filt;
  wire [7:0] rise;
  wire [31:0] freq [0:NCH-1];
  wire [7:0] freqUpd;
  wire [7:0] latSetHi;
  wire [7:0] latSetLo;
  wire [2:0] events;
  wire wrCtrl;
  wire wrCclr;
  wire wrIsts;
  wire wrDout;
  wire wrPreset;
  reg [31:0] rdMux;
  integer c;
  integer n; // loop index of the counter block

  // single cycle slave: never stalls, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign accept = hsel && hready && htrans[1];

  // remember the address phase of a write
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
    end
    else if (hready)
    begin
      wrPend_q <= accept && hwrite;
      wrAddr_q <= haddr[7:0];
    end
  end

  // write strobes for registers with side effects
  assign wrCtrl = wrPend_q && (wrAddr_q == `DCC_REG_CTRL);
  assign wrCclr = wrPend_q && (wrAddr_q == `DCC_REG_CCLR);
  assign wrIsts = wrPend_q && (wrAddr_q == `DCC_REG_ISTS);
  assign wrDout = wrPend_q && (wrAddr_q == `DCC_REG_DOUT);
  assign wrPreset = wrPend_q && (wrAddr_q[7:5] == 3'h2);

  // plain config registers
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ctrl_q <= `DCC_CTRL_RST;
      wdtTo_q <= `DCC_WDT_RST;
      safeEn_q <= 8'h00;
      safeVal_q <= 8'h00;
      powerOn_q <= `DCC_PWRON_RST;
      filtMs_q <= `DCC_FILT_RST; // [R9]
      cntEn_q <= 8'h00;
      freqEn_q <= 8'h00;
      irqMsk_q <= 3'h0;
      for (c = 0; c < NCH; c = c + 1)
        preset_q[c] <= 32'h0000_0000;
    end
    else if (wrPend_q)
    begin
      // clear bits are strobes; they never stay stored
      if (wrCtrl)
        ctrl_q <= hwdata & 32'h0000_0331;
      else if (wrAddr_q == `DCC_REG_WDT)
        wdtTo_q <= hwdata[15:0];
      else if (wrAddr_q == `DCC_REG_SAFE)
      begin
        safeEn_q <= hwdata[7:0]; // [R2]
        safeVal_q <= hwdata[15:8];
        powerOn_q <= hwdata[23:16];
      end
      else if (wrAddr_q == `DCC_REG_FILT)
      begin
        // values of hwdata[15:0] above the top of the range are clamped
        if (hwdata[15:0] > 16'd6500)
          filtMs_q <= 13'd6500;
        else
          filtMs_q <= hwdata[12:0]; // [R9]
      end
      else if (wrAddr_q == `DCC_REG_ENAB)
      begin
        cntEn_q <= hwdata[7:0]; // [R10]
        freqEn_q <= hwdata[15:8]; // [R13]
      end
      else if (wrAddr_q == `DCC_REG_IMSK)
        irqMsk_q <= hwdata[2:0];
      else if (wrPreset)
        preset_q[chIdx(wrAddr_q)] <= hwdata; // [R12]
    end
  end

  // millisecond and microsecond time base
  assign msTick = (msCnt_q == MS_CYC - 1);
  assign usTick = (usCnt_q == US_CYC - 1);
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      msCnt_q <= 17'h00000;
      usCnt_q <= 7'h00;
    end
    else
    begin
      msCnt_q <= msTick ? 17'h00000 : msCnt_q + 17'h00001;
      usCnt_q <= usTick ? 7'h00 : usCnt_q + 7'h01;
    end
  end

  // host watchdog; a request in the same cycle cancels the trip
  assign alarmSet = !mbReq && !alarm_q && wdtTo_q != 16'h0000 &&
                    msTick && (wdtMs_q + 16'h0001 >= wdtTo_q); // [R1]
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wdtMs_q <= 16'h0000;
      alarm_q <= 1'b0;
    end
    else if (mbReq)
    begin
      wdtMs_q <= 16'h0000; // [R18]
      alarm_q <= 1'b0; // [R18]
    end
    else if (alarmSet)
      alarm_q <= 1'b1; // [R1]
    else if (msTick && !alarm_q && wdtTo_q != 16'h0000)
      wdtMs_q <= wdtMs_q + 16'h0001;
  end

  // output values; enabled channels stay safe while alarmed
  always @(posedge sys_clk)
  begin
    if (!resetn)
      doVal_q <= `DCC_PWRON_RST; // [R4]
    else if (alarmSet)
      doVal_q <= (doVal_q & ~safeEn_q) | (safeVal_q & safeEn_q); // [R3]
    else if (wrDout && alarm_q)
      doVal_q <= (hwdata[7:0] & ~safeEn_q) | (doVal_q & safeEn_q); // [R3]
    else if (wrDout)
      doVal_q <= hwdata[7:0];
  end
  assign doPin = doVal_q;

  // per-channel input filter and frequency meter
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1)
    begin : gCh
      dcc_in_filter uFilt
      (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .pinIn(diPin[g]),
        .msTick(msTick),
        .filterMs(filtMs_q),
        .filtOut(filt[g])
      );
      dcc_freq_chan uFreq
      (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .en(freqEn_q[g]), // [R13]
        .mode(ctrl_q[`DCC_CTRL_MODE_LSB+1:`DCC_CTRL_MODE_LSB]),
        .avgSel(ctrl_q[`DCC_CTRL_AVG_LSB+1:`DCC_CTRL_AVG_LSB]),
        .rise(rise[g]),
        .msTick(msTick),
        .usTick(usTick),
        .freq(freq[g]),
        .upd(freqUpd[g])
      );
    end
  endgenerate

  // edge detect on the filtered levels
  always @(posedge sys_clk)
  begin
    if (!resetn)
      filtPrev_q <= 8'h00;
    else
      filtPrev_q <= filt;
  end
  assign rise = filt & ~filtPrev_q;

  // latches; a level seen in the clear cycle still sets
  assign latSetHi = ctrl_q[`DCC_CTRL_LATEN] ? filt : 8'h00; // [R5]
  assign latSetLo = ctrl_q[`DCC_CTRL_LATEN] ? ~filt : 8'h00; // [R5]
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      hiLat_q <= 8'h00;
      loLat_q <= 8'h00;
    end
    else
    begin
      if (wrCtrl && hwdata[`DCC_CTRL_CLRHI])
        hiLat_q <= latSetHi; // [R7]
      else
        hiLat_q <= hiLat_q | latSetHi; // [R6]
      if (wrCtrl && hwdata[`DCC_CTRL_CLRLO])
        loLat_q <= latSetLo; // [R8]
      else
        loLat_q <= loLat_q | latSetLo; // [R6]
    end
  end

  // pulse counters; clear reloads the preset
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      for (n = 0; n < NCH; n = n + 1)
        count_q[n] <= 32'h0000_0000;
    end
    else
    begin
      for (n = 0; n < NCH; n = n + 1)
      begin
        if (wrCclr && hwdata[n])
          count_q[n] <= preset_q[n]; // [R11] [R12]
        else if (cntEn_q[n] && rise[n])
          count_q[n] <= count_q[n] + 32'h0000_0001; // [R10] [R19]
      end
    end
  end

  // sticky interrupt status, write one to clear, set wins
  assign events[`DCC_IRQ_ALARM] = alarmSet;
  assign events[`DCC_IRQ_LATCH] = |((latSetHi & ~hiLat_q) |
                                    (latSetLo & ~loLat_q));
  assign events[`DCC_IRQ_FREQ] = |freqUpd;
  always @(posedge sys_clk)
  begin
    if (!resetn)
      irqSts_q <= 3'h0;
    else if (wrIsts)
      irqSts_q <= (irqSts_q & ~hwdata[2:0]) | events;
    else
      irqSts_q <= irqSts_q | events;
  end
  assign irq = |(irqSts_q & irqMsk_q);

  // read decode, unmapped addresses read zero
  always @*
  begin
    rdMux = 32'h0000_0000;
    if (haddr[7:0] == `DCC_REG_CTRL)
      rdMux = ctrl_q;
    else if (haddr[7:0] == `DCC_REG_WDT)
      rdMux = {16'h0000, wdtTo_q};
    else if (haddr[7:0] == `DCC_REG_SAFE)
      rdMux = {8'h00, powerOn_q, safeVal_q, safeEn_q};
    else if (haddr[7:0] == `DCC_REG_DOUT)
      rdMux = {24'h000000, doVal_q};
    else if (haddr[7:0] == `DCC_REG_DIN)
      rdMux = {7'h00, alarm_q, loLat_q, hiLat_q, filt};
    else if (haddr[7:0] == `DCC_REG_FILT)
      rdMux = {19'h00000, filtMs_q};
    else if (haddr[7:0] == `DCC_REG_ENAB)
      rdMux = {16'h0000, freqEn_q, cntEn_q};
    else if (haddr[7:0] == `DCC_REG_ISTS)
      rdMux = {29'h0, irqSts_q};
    else if (haddr[7:0] == `DCC_REG_IMSK)
      rdMux = {29'h0, irqMsk_q};
    else if (haddr[7:5] == 3'h2)
      rdMux = preset_q[chIdx(haddr[7:0])];
    else if (haddr[7:5] == 3'h3)
      rdMux = count_q[chIdx(haddr[7:0])];
    else if (haddr[7:5] == 3'h4)
      rdMux = freq[chIdx(haddr[7:0])];
  end

  // read data captured at the address phase
  always @(posedge sys_clk)
  begin
    if (!resetn)
      hrdata <= 32'h0000_0000;
    else if (accept && !hwrite)
      hrdata <= rdMux;
  end
endmodule

// ---- test/dcc_chk_sva.sv ----
`timescale 1ns/1ps
`include "dcc_map.vh"
// port-level checker for the channel control block
module dcc_chk_sva
#(
  parameter MS_CYC = 100000
)
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // register bus
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // host, pins, interrupt
  input wire mbReq,
  input wire [7:0] diPin,
  input wire [7:0] doPin,
  input wire irq
);
  wire take = hsel && hready && htrans[1]; // transfer taken
  wire rdTake = take && !hwrite; // read taken
  reg wrPend_q; // write in data phase
  reg [7:0] wrAddr_q; // its offset
  reg anyWr_q; // some write has landed
  reg maskOff_q; // mask known all zero
  // track writes, so port checks need no view inside
  always @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wrPend_q <= 1'b0;
      wrAddr_q <= 8'h00;
      anyWr_q <= 1'b0;
      maskOff_q <= 1'b1;
    end
    else
    begin
      wrPend_q <= take && hwrite;
      wrAddr_q <= haddr[7:0];
      if (wrPend_q)
        anyWr_q <= 1'b1;
      if (wrPend_q && wrAddr_q == `DCC_REG_IMSK)
        maskOff_q <= (hwdata == 32'h0);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ready_high_a: assert property (hreadyout)
    else $error("slave inserted a wait");
  resp_okay_a: assert property (!hresp)
    else $error("slave answered an error");
  pwron_out_a: assert property (!anyWr_q |-> doPin == 8'h00)
    else $error("outputs left power-on value unasked");
  // reset itself is the cause here, so this one is never disabled
  rst_quiet_a: assert property (disable iff (1'b0)
    !resetn |=> !irq && doPin == 8'h00)
    else $error("reset did not quiet outputs");
  rd_hold_a: assert property (!rdTake |=> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property (rdTake && haddr[7:0] == 8'h30
    |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  wo_clear_a: assert property (rdTake && haddr[7:0] == `DCC_REG_CCLR
    |=> hrdata == 32'h0)
    else $error("clear control read not zero");
  mask_irq_a: assert property (maskOff_q |-> !irq)
    else $error("interrupt while all masked");
  cover property (irq);
  cover property (rdTake ##2 rdTake);
  cover property ($changed(doPin));
endmodule

bind dcc_top dcc_chk_sva #(.MS_CYC(MS_CYC)) chk (.sys_clk(sys_clk),
  .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mbReq(mbReq),
  .diPin(diPin), .doPin(doPin), .irq(irq));

// ---- test/dcc_host_model.sv ----
`timescale 1ns/1ps
// remote host: one request pulse every gap+1 cycles while talking
module dcc_host_model
(
  // clock and reset
  input wire sys_clk,
  input wire resetn,
  // traffic control
  input wire talk,
  input wire [7:0] gap,
  // request pulse
  output reg mbReq
);
  reg [7:0] cnt_q; // cycles since last request
  // a long gap lets the watchdog come close to its limit
  always @(posedge sys_clk)
  begin
    if (!resetn || !talk)
    begin
      cnt_q <= 8'h00;
      mbReq <= 1'b0;
    end
    else
    begin
      cnt_q <= (cnt_q >= gap) ? 8'h00 : cnt_q + 8'h01;
      mbReq <= (cnt_q == 8'h00);
    end
  end
endmodule

// ---- test/dcc_tb.sv ----
`timescale 1ns/1ps
`include "dcc_map.vh"
// self-checking bench for the channel control block
module tb;
  localparam MS = 20; // shortened millisecond, in cycles
  logic sys_clk, resetn, hsel, hwrite, talk, sig;
  logic [31:0] haddr, hwdata;
  logic [1:0] htrans;
  logic [7:0] diBase, gap;
  logic [15:0] half, hcnt;
  int num_errors, n_tests, cyc;
  wire hreadyout, hresp, mbReq, irq;
  wire [31:0] hrdata;
  wire [7:0] doPin;
  // square wave rides on channels 1 and 2
  dcc_top #(.MS_CYC(MS)) dut (.sys_clk(sys_clk), .resetn(resetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .mbReq(mbReq),
    .diPin(diBase | {5'h00, sig, sig, 1'b0}), .doPin(doPin), .irq(irq));
  dcc_host_model host (.sys_clk(sys_clk), .resetn(resetn), .talk(talk),
    .gap(gap), .mbReq(mbReq));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // wave generator, half period in cycles, zero stops it
  always @(posedge sys_clk)
  begin
    hcnt <= (half == 0 || hcnt + 1 >= half) ? 16'h0000 : hcnt + 1;
    sig <= (half == 0) ? 1'b0 : sig ^ (hcnt + 1 >= half);
  end
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      num_errors++;
      end_sim;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task waitc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // one bus transfer; read data taken at the data-phase edge
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(hrdata, exp);
  endtask
  task t_reset;
    chk({24'h0, doPin}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rdc(`DCC_REG_FILT, 32'h0);
    rdc(`DCC_REG_CTRL, 32'h0);
    rdc(`DCC_REG_CCLR, 32'h0);
    rdc(8'h30, 32'h0);
  endtask
  task t_latch;
    wr(`DCC_REG_CTRL, 32'h1);
    diBase <= 8'h0f;
    waitc(8);
    diBase <= 8'h00;
    waitc(8);
    rdc(`DCC_REG_DIN, 32'h00ff0f00);
    wr(`DCC_REG_CTRL, 32'h1);
    rdc(`DCC_REG_DIN, 32'h00ff0f00);
    wr(`DCC_REG_CTRL, 32'h3);
    rdc(`DCC_REG_DIN, 32'h00ff0000);
    diBase <= 8'hff;
    waitc(8);
    wr(`DCC_REG_CTRL, 32'h5);
    rdc(`DCC_REG_DIN, 32'h0000ffff);
    // latching is still on at this edge, so the high level sets again
    wr(`DCC_REG_CTRL, 32'h6);
    diBase <= 8'h00;
    waitc(8);
    rdc(`DCC_REG_DIN, 32'h0000ff00);
    wr(`DCC_REG_CTRL, 32'h2);
    rdc(`DCC_REG_DIN, 32'h0);
  endtask
  task t_filter;
    wr(`DCC_REG_FILT, 32'd7000);
    rdc(`DCC_REG_FILT, 32'd6500);
    wr(`DCC_REG_FILT, 32'd2);
    diBase <= 8'h01;
    waitc(10);
    diBase <= 8'h00;
    waitc(100);
    rdc(`DCC_REG_DIN, 32'h0);
    diBase <= 8'h01;
    waitc(15);
    rdc(`DCC_REG_DIN, 32'h0);
    waitc(85);
    rdc(`DCC_REG_DIN, 32'h1);
    diBase <= 8'h00;
    wr(`DCC_REG_FILT, 32'h0);
    waitc(8);
  endtask
  task t_count;
    wr(`DCC_REG_PRESET, 32'h10);
    wr(`DCC_REG_PRESET + 8'h04, 32'h5);
    wr(`DCC_REG_ENAB, 32'h1);
    wr(`DCC_REG_CCLR, 32'h3);
    rdc(`DCC_REG_COUNT, 32'h10);
    rdc(`DCC_REG_COUNT + 8'h04, 32'h5);
    repeat (3)
    begin
      diBase <= 8'hff;
      waitc(6);
      diBase <= 8'h00;
      waitc(6);
    end
    rdc(`DCC_REG_COUNT, 32'h13);
    rdc(`DCC_REG_COUNT + 8'h04, 32'h5);
    wr(`DCC_REG_CCLR, 32'h1);
    rdc(`DCC_REG_COUNT, 32'h10);
    wr(`DCC_REG_ENAB, 32'h0);
  endtask
  task t_wdog;
    wr(`DCC_REG_ISTS, 32'h7);
    wr(`DCC_REG_SAFE, 32'h0000050f);
    wr(`DCC_REG_DOUT, 32'ha0);
    wr(`DCC_REG_IMSK, 32'h1);
    wr(`DCC_REG_WDT, 32'h3);
    gap <= 8'd20;
    talk <= 1'b1;
    waitc(200);
    chk({31'h0, irq}, 32'h0);
    talk <= 1'b0;
    waitc(100);
    chk({31'h0, irq}, 32'h1);
    chk({24'h0, doPin}, 32'ha5);
    rdc(`DCC_REG_DIN, 32'h01000000);
    wr(`DCC_REG_DOUT, 32'hff);
    waitc(1);
    chk({24'h0, doPin}, 32'hf5);
    gap <= 8'd40;
    talk <= 1'b1;
    waitc(10);
    rdc(`DCC_REG_DIN, 32'h0);
    waitc(200);
    rdc(`DCC_REG_DIN, 32'h0);
    wr(`DCC_REG_ISTS, 32'h1);
    waitc(1);
    chk({31'h0, irq}, 32'h0);
    wr(`DCC_REG_IMSK, 32'h0);
    talk <= 1'b0;
    waitc(100);
    chk({31'h0, irq}, 32'h0);
    rdc(`DCC_REG_ISTS, 32'h1);
    wr(`DCC_REG_WDT, 32'h0);
    talk <= 1'b1;
  endtask
  task t_freq;
    wr(`DCC_REG_CTRL, 32'h210);
    half <= 16'd10;
    wr(`DCC_REG_ENAB, 32'h200);
    waitc(13000);
    rdc(`DCC_REG_FREQ + 8'h04, 32'd100000);
    rdc(`DCC_REG_FREQ + 8'h08, 32'h0);
    wr(`DCC_REG_CTRL, 32'h000);
    half <= 16'd20;
    waitc(41000);
    rdc(`DCC_REG_FREQ + 8'h04, 32'd50000);
    // 10 us period is 100 kHz, counted in 0.01 Hz steps
    wr(`DCC_REG_CTRL, 32'h320);
    half <= 16'd500;
    waitc(12000);
    rdc(`DCC_REG_FREQ + 8'h04, 32'd10000000);
    wr(`DCC_REG_CTRL, 32'h120);
    waitc(3000);
    rdc(`DCC_REG_FREQ + 8'h04, 32'd10000000);
    half <= 16'd0;
    wr(`DCC_REG_ENAB, 32'h0);
    // alarm and frequency update events stay sticky
    rdc(`DCC_REG_ISTS, 32'h5);
  endtask
  task end_sim;
    $display("errors=%0d tests=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    {resetn, hsel, hwrite, talk, haddr, hwdata, htrans} = '0;
    {diBase, gap, half, hcnt, sig} = '0;
    {num_errors, n_tests, cyc} = '0;
    waitc(8);
    resetn <= 1'b1;
    waitc(1);
    t_reset;
    t_latch;
    t_filter;
    t_count;
    t_wdog;
    t_freq;
    end_sim;
  end
endmodule
